/* File: rtl/srf_cmd_ctrl.sv */
// Decoder for the error recovery control and feature control key sectors,
// with the recovery timer applied to media commands.
// Assumes key sector words and media command events come from logic on
// the same clock; other action codes are handled elsewhere.
//
// Operation
// - Action 0003h: set or return read/write limit
// - Limit in word 3, units of 100 ms
// - Abort set when limit below 65 units
// - Return limit in count/number, 00h and 50h
// - Non-queued: limit runs until host completion
// - Queued in-order: timer starts at delivery
// - No limit for streaming or out-of-order queued
// - Limits volatile, zero after reset, zero disables
// - Action 0004h: set state, get state, get flags
// - Feature code, state, flags in words 2-4
// - Flag bit 0 set: state survives power cycles; the store here keeps it through hard reset only, cold reset loads the default
// - Flag bit 0 clear: volatile, reset restores
// - State or flags returned in count/number
module srf_cmd_ctrl #(
    parameter int UNIT_CYCLES = srf_pkg::SRF_UNIT_CYCLES
) (
    // Clock and resets
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cold_rst_i,
    // Key sector
    input  wire logic        key_valid_i,
    input  wire logic [15:0] key_action_i,
    input  wire logic [15:0] key_function_i,
    input  wire logic [15:0] key_word2_i,
    input  wire logic [15:0] key_word3_i,
    input  wire logic [15:0] key_word4_i,
    input  wire logic        key_rsvd_zero_i,
    // Task file result
    output logic             tf_done_o,
    output logic [7:0]       tf_error_o,
    output logic [7:0]       tf_sec_cnt_o,
    output logic [7:0]       tf_sec_num_o,
    output logic [7:0]       tf_status_o,
    // Current settings
    output logic [15:0]      read_limit_o,
    output logic [15:0]      write_limit_o,
    output logic [15:0]      feat1_state_o,
    output logic [15:0]      feat2_state_o,
    output logic [15:0]      feat3_state_o,
    // Persistent store request
    output logic             nv_save_o,
    output logic [15:0]      nv_feature_o,
    output logic [15:0]      nv_state_o,
    // Media command timing
    input  wire logic        mcmd_start_i,
    input  wire logic        mcmd_write_i,
    input  wire logic        mcmd_queued_i,
    input  wire logic        mcmd_in_order_i,
    input  wire logic        mcmd_stream_i,
    input  wire logic        mcmd_done_i,
    output logic             mcmd_timeout_o
);

    ////////////////////////////////////////////////////////////////////////
    // Key sector decode

    wire is_recovery = key_valid_i && (key_action_i == srf_pkg::SRF_ACT_RECOVERY);
    wire is_feature  = key_valid_i && (key_action_i == srf_pkg::SRF_ACT_FEATURE);
    wire fn_set      = (key_function_i == srf_pkg::SRF_FN_SET);
    wire fn_get      = (key_function_i == srf_pkg::SRF_FN_GET);
    wire fn_flags    = (key_function_i == srf_pkg::SRF_FN_FLAGS);
    wire sel_read    = (key_word2_i == srf_pkg::SRF_SEL_READ);
    wire sel_write   = (key_word2_i == srf_pkg::SRF_SEL_WRITE);

    // Limit is a count of 100 ms units, compared as such
    wire limit_short = (key_word3_i < srf_pkg::SRF_LIMIT_MIN);

    wire rec_fn_ok   = fn_set || fn_get;
    wire rec_sel_ok  = sel_read || sel_write;
    wire rec_ok      = rec_fn_ok && rec_sel_ok && key_rsvd_zero_i &&
                       !(fn_set && limit_short);
    wire rec_set     = is_recovery && rec_ok && fn_set;
    wire rec_get     = is_recovery && rec_ok && fn_get;

    // Feature code in word 2, state in word 3, flags in word 4
    wire feat_code_ok = (key_word2_i >= srf_pkg::SRF_FEAT_FIRST) &&
                        (key_word2_i <= srf_pkg::SRF_FEAT_LAST);
    wire feat_fn_ok   = fn_set || fn_get || fn_flags;
    wire feat_ok      = feat_fn_ok && feat_code_ok && key_rsvd_zero_i;
    wire feat_set     = is_feature && feat_ok && fn_set;
    wire feat_get     = is_feature && feat_ok && fn_get;
    wire feat_getf    = is_feature && feat_ok && fn_flags;
    wire persist      = key_word4_i[srf_pkg::SRF_FLAG_PERSIST];

    wire [1:0] feat_idx = key_word2_i[1:0] - 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Recovery limits

    logic [15:0] read_limit;
    logic [15:0] write_limit;

    // Volatile only: hard reset always brings the limits back to zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            read_limit  <= srf_pkg::SRF_LIMIT_RST;
            write_limit <= srf_pkg::SRF_LIMIT_RST;
        end else if (rec_set) begin
            if (sel_read) begin
                read_limit <= key_word3_i;
            end else begin
                write_limit <= key_word3_i;
            end
        end
    end

    wire [15:0] sel_limit = sel_read ? read_limit : write_limit;

    ////////////////////////////////////////////////////////////////////////
    // Feature store, one entry per listed feature code

    logic [15:0] vol_state [srf_pkg::SRF_NUM_FEAT];
    logic [15:0] nv_state  [srf_pkg::SRF_NUM_FEAT];
    logic        vol_flag  [srf_pkg::SRF_NUM_FEAT];
    logic        nv_flag   [srf_pkg::SRF_NUM_FEAT];

    genvar g;
    generate
        for (g = 0; g < srf_pkg::SRF_NUM_FEAT; g++) begin : g_feat
            wire hit = feat_set && (feat_idx == 2'(g));

            // Persistent copy lives through hard reset; cold reset loads the default state and clears the flag
            always_ff @(posedge clock_i) begin
                if (cold_rst_i) begin
                    nv_state[g] <= srf_pkg::SRF_FEAT_DEFAULT;
                    nv_flag[g]  <= srf_pkg::SRF_FLAG_RST;
                end else if (hit && persist) begin
                    nv_state[g] <= key_word3_i;
                    nv_flag[g]  <= 1'b1;
                end
            end

            always_ff @(posedge clock_i) begin
                if (cold_rst_i) begin
                    vol_state[g] <= srf_pkg::SRF_FEAT_DEFAULT;
                    vol_flag[g]  <= srf_pkg::SRF_FLAG_RST;
                end else if (sys_rst_i) begin
                    vol_state[g] <= nv_state[g];
                    vol_flag[g]  <= nv_flag[g];
                end else if (hit) begin
                    vol_state[g] <= key_word3_i;
                    vol_flag[g]  <= persist;
                end
            end
        end
    endgenerate

    wire [15:0] cur_state = vol_state[feat_idx];
    wire [15:0] cur_flags = {15'h0000, vol_flag[feat_idx]};

    ////////////////////////////////////////////////////////////////////////
    // Task file answer

    wire        our_cmd   = is_recovery || is_feature;
    wire        good      = rec_set || rec_get || feat_set || feat_get || feat_getf;
    wire [15:0] ret_word  = rec_get   ? sel_limit :
                            feat_get  ? cur_state :
                            feat_getf ? cur_flags : 16'h0000;
    wire        ret_valid = rec_get || feat_get || feat_getf;

    wire [7:0]  next_error   = good ? srf_pkg::SRF_ERR_NONE : srf_pkg::SRF_ERR_ABORT;
    wire [7:0]  next_status  = good ? srf_pkg::SRF_STAT_OK : srf_pkg::SRF_STAT_ERR;
    wire [7:0]  next_sec_cnt = ret_valid ? ret_word[7:0]  : srf_pkg::SRF_BYTE_RSVD;
    wire [7:0]  next_sec_num = ret_valid ? ret_word[15:8] : srf_pkg::SRF_BYTE_RSVD;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tf_done_o    <= 1'b0;
            tf_error_o   <= srf_pkg::SRF_ERR_NONE;
            tf_sec_cnt_o <= srf_pkg::SRF_BYTE_RSVD;
            tf_sec_num_o <= srf_pkg::SRF_BYTE_RSVD;
            tf_status_o  <= srf_pkg::SRF_STAT_OK;
        end else begin
            tf_done_o <= our_cmd;
            // Answer bytes hold until the next decoded key sector
            if (our_cmd) begin
                tf_error_o   <= next_error;
                tf_sec_cnt_o <= next_sec_cnt;
                tf_sec_num_o <= next_sec_num;
                tf_status_o  <= next_status;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Persistent store request and setting outputs

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            nv_save_o    <= 1'b0;
            nv_feature_o <= 16'h0000;
            nv_state_o   <= 16'h0000;
        end else begin
            nv_save_o <= feat_set && persist;
            if (feat_set && persist) begin
                nv_feature_o <= key_word2_i;
                nv_state_o   <= key_word3_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            read_limit_o  <= srf_pkg::SRF_LIMIT_RST;
            write_limit_o <= srf_pkg::SRF_LIMIT_RST;
        end else begin
            read_limit_o  <= read_limit;
            write_limit_o <= write_limit;
        end
    end

    // One cycle behind the store; cold reset also reloads these
    always_ff @(posedge clock_i) begin
        if (cold_rst_i) begin
            feat1_state_o <= srf_pkg::SRF_FEAT_DEFAULT;
            feat2_state_o <= srf_pkg::SRF_FEAT_DEFAULT;
            feat3_state_o <= srf_pkg::SRF_FEAT_DEFAULT;
        end else begin
            feat1_state_o <= vol_state[0];
            feat2_state_o <= vol_state[1];
            feat3_state_o <= vol_state[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media command recovery timer

    logic tick;

    srf_tick_div #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_tick (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (tick)
    );

    // Non-queued and in-order queued commands both start at delivery and
    // stop at host completion; streaming and out-of-order are never timed
    wire        mcmd_apply = !mcmd_stream_i &&
                             (!mcmd_queued_i || mcmd_in_order_i);
    wire [15:0] mcmd_limit = mcmd_write_i ? write_limit : read_limit;

    logic expired;

    srf_recovery_timer u_timer (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick),
        .start_i   (mcmd_start_i),
        .apply_i   (mcmd_apply),
        .stop_i    (mcmd_done_i),
        .limit_i   (mcmd_limit),
        .expired_o (expired)
    );

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mcmd_timeout_o <= 1'b0;
        end else begin
            mcmd_timeout_o <= expired;
        end
    end

endmodule

/* File: rtl/srf_pkg.sv */
// Constants shared by the recovery and feature control command decoder.
// Assumes a 100 MHz core clock and 16-bit key sector words.
package srf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Key sector codes
    localparam logic [15:0] SRF_ACT_RECOVERY = 16'h0003;
    localparam logic [15:0] SRF_ACT_FEATURE  = 16'h0004;
    localparam logic [15:0] SRF_FN_SET       = 16'h0001;
    localparam logic [15:0] SRF_FN_GET       = 16'h0002;
    localparam logic [15:0] SRF_FN_FLAGS     = 16'h0003;
    localparam logic [15:0] SRF_SEL_READ     = 16'h0001;
    localparam logic [15:0] SRF_SEL_WRITE    = 16'h0002;

    ////////////////////////////////////////////////////////////////////////
    // Limits, reset values and feature table
    localparam logic [15:0] SRF_LIMIT_MIN     = 16'h0041;
    localparam logic [15:0] SRF_LIMIT_RST     = 16'h0000;
    localparam int          SRF_NUM_FEAT      = 3;
    localparam logic [15:0] SRF_FEAT_FIRST    = 16'h0001;
    localparam logic [15:0] SRF_FEAT_LAST     = 16'h0003;
    localparam logic [15:0] SRF_FEAT_DEFAULT  = 16'h0001;
    localparam int          SRF_FLAG_PERSIST  = 0;
    localparam logic        SRF_FLAG_RST      = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Task file answers
    localparam logic [7:0]  SRF_ERR_NONE  = 8'h00;
    localparam logic [7:0]  SRF_ERR_ABORT = 8'h04;
    localparam logic [7:0]  SRF_STAT_OK   = 8'h50;
    localparam logic [7:0]  SRF_STAT_ERR  = 8'h51;
    localparam logic [7:0]  SRF_BYTE_RSVD = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          SRF_CLK_MHZ     = 100;
    localparam int          SRF_UNIT_MS     = 100;
    localparam int          SRF_UNIT_CYCLES = SRF_UNIT_MS * 1000 * SRF_CLK_MHZ;
    localparam int          SRF_DIV_W       = 24;

endpackage

/* File: rtl/srf_recovery_timer.sv */
// One recovery timer counting unit ticks against a limit.
// Assumes start and stop are one-cycle pulses on the core clock.
module srf_recovery_timer (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Control
    input  wire logic        tick_i,
    input  wire logic        start_i,
    input  wire logic        apply_i,
    input  wire logic        stop_i,
    input  wire logic [15:0] limit_i,
    // Result
    output logic             expired_o
);

    logic        active;
    logic [15:0] units;
    logic [15:0] limit;

    wire         reach = active && tick_i && ((units + 16'h0001) == limit);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            active    <= 1'b0;
            units     <= 16'h0000;
            limit     <= srf_pkg::SRF_LIMIT_RST;
            expired_o <= 1'b0;
        end else begin
            expired_o <= reach;
            if (start_i) begin
                // Zero limit means no time-out at all
                active <= apply_i && (limit_i != srf_pkg::SRF_LIMIT_RST);
                units  <= 16'h0000;
                limit  <= limit_i;
            end else if (stop_i || reach) begin
                active <= 1'b0;
            end else if (active && tick_i) begin
                units <= units + 16'h0001;
            end
        end
    end

endmodule

/* File: rtl/srf_tick_div.sv */
// Divider making one enable pulse per recovery time unit.
// Assumes the count fits the counter width of the package.
module srf_tick_div #(
    parameter int UNIT_CYCLES = srf_pkg::SRF_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    // Enable
    output logic      tick_o
);

    localparam int                            DIV_W = srf_pkg::SRF_DIV_W;
    localparam logic [srf_pkg::SRF_DIV_W-1:0] LAST  = DIV_W'(UNIT_CYCLES - 1);

    logic [srf_pkg::SRF_DIV_W-1:0] count;
    wire                           at_last = (count == LAST);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            count  <= at_last ? '0 : count + 1'b1;
            tick_o <= at_last;
        end
    end

endmodule

/* File: tb/srf_cmd_ctrl_checker.sv */
// Checker on the decoder's task file answers, settings and timer pulse.
// Assumes it is bound to srf_cmd_ctrl and sees only its ports.
module srf_cmd_ctrl_checker (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    // Key sector
    input wire logic        key_valid_i,
    input wire logic [15:0] key_action_i,
    input wire logic [15:0] key_function_i,
    input wire logic [15:0] key_word2_i,
    input wire logic [15:0] key_word3_i,
    input wire logic [15:0] key_word4_i,
    input wire logic        key_rsvd_zero_i,
    // Answers and settings
    input wire logic        tf_done_o,
    input wire logic [7:0]  tf_error_o,
    input wire logic [7:0]  tf_sec_cnt_o,
    input wire logic [7:0]  tf_sec_num_o,
    input wire logic [7:0]  tf_status_o,
    input wire logic [15:0] read_limit_o,
    input wire logic [15:0] write_limit_o,
    input wire logic        nv_save_o,
    input wire logic [15:0] nv_state_o,
    input wire logic        mcmd_timeout_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////
    wire is_rec = key_valid_i && key_action_i == srf_pkg::SRF_ACT_RECOVERY;
    wire is_fea = key_valid_i && key_action_i == srf_pkg::SRF_ACT_FEATURE;
    wire fn_set = key_function_i == srf_pkg::SRF_FN_SET && key_rsvd_zero_i;
    wire rd_sel = key_word2_i == srf_pkg::SRF_SEL_READ && key_rsvd_zero_i;
    wire fea_ok = is_fea && key_rsvd_zero_i && key_word2_i >= srf_pkg::SRF_FEAT_FIRST
                  && key_word2_i <= srf_pkg::SRF_FEAT_LAST;
    wire keep   = key_word4_i[srf_pkg::SRF_FLAG_PERSIST];

    ////////////////////////////////////////
    chk_done_follows: assert property (
        (is_rec || is_fea) |=> tf_done_o) else $error("No done after decoded key sector");
    chk_other_silent: assert property (
        !(is_rec || is_fea) |=> !tf_done_o) else $error("Done without decoded key sector");
    chk_min_limit: assert property (
        is_rec && fn_set && rd_sel && key_word3_i < srf_pkg::SRF_LIMIT_MIN
        |=> tf_error_o == srf_pkg::SRF_ERR_ABORT) else $error("Short limit not aborted");
    chk_set_limit: assert property (
        is_rec && fn_set && rd_sel && key_word3_i >= srf_pkg::SRF_LIMIT_MIN
        |=> tf_error_o == 8'h00 ##1 read_limit_o == $past(key_word3_i, 2)) else $error("Limit not stored");
    chk_get_limit: assert property (
        is_rec && key_function_i == srf_pkg::SRF_FN_GET && rd_sel
        |=> {tf_sec_num_o, tf_sec_cnt_o} == read_limit_o && tf_status_o == 8'h50) else $error("Bad limit answer");
    chk_reset_clear: assert property (
        $fell(sys_rst_i) |-> read_limit_o == 16'h0000 && write_limit_o == 16'h0000 && !tf_done_o)
        else $error("Limits not cleared by reset");
    chk_bad_code: assert property (
        is_fea && !(key_function_i inside {16'h0001, 16'h0002, 16'h0003})
        |=> tf_error_o == 8'h04) else $error("Unlisted function not aborted");
    chk_rsvd_abort: assert property (
        (is_rec || is_fea) && !key_rsvd_zero_i |=> tf_status_o == 8'h51) else $error("Reserved words ignored");
    chk_persist_save: assert property (
        fea_ok && fn_set && keep |=> nv_save_o && nv_state_o == $past(key_word3_i))
        else $error("Persistent set not saved");
    chk_volatile_set: assert property (
        fea_ok && fn_set && !keep |=> !nv_save_o) else $error("Volatile set saved");
    chk_flags_word: assert property (
        fea_ok && key_function_i == srf_pkg::SRF_FN_FLAGS
        |=> tf_sec_num_o == 8'h00 && tf_sec_cnt_o[7:1] == 7'h00) else $error("Reserved flag bits set");
    chk_timeout_pulse: assert property (
        mcmd_timeout_o |=> !mcmd_timeout_o) else $error("Time-out longer than one cycle");
endmodule

bind srf_cmd_ctrl srf_cmd_ctrl_checker chk (.*);

/* File: tb/srf_host_model.sv */
// Host model handing key sectors to the decoder, one per send pulse.
// Assumes the bench drives its requests at the rising clock edge.
module srf_host_model (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Request from the bench
    input  wire logic        send_i,
    input  wire logic [15:0] action_i,
    input  wire logic [15:0] function_i,
    input  wire logic [15:0] word2_i,
    input  wire logic [15:0] word3_i,
    input  wire logic        persist_i,
    input  wire logic        rsvd_zero_i,
    // Key sector to the decoder
    output logic             key_valid_o,
    output logic [15:0]      key_action_o,
    output logic [15:0]      key_function_o,
    output logic [15:0]      key_word2_o,
    output logic [15:0]      key_word3_o,
    output logic [15:0]      key_word4_o,
    output logic             key_rsvd_zero_o
);
    always_ff @(posedge clock_i) begin
        key_valid_o <= send_i && !sys_rst_i;
        if (sys_rst_i) begin
            {key_action_o, key_function_o, key_word2_o} <= 48'h0;
            {key_word3_o, key_word4_o, key_rsvd_zero_o} <= 33'h0;
        end else if (send_i) begin
            {key_action_o, key_function_o} <= {action_i, function_i};
            key_word2_o     <= word2_i;
            key_word3_o     <= word3_i;
            key_word4_o     <= {15'h0000, persist_i};
            key_rsvd_zero_o <= rsvd_zero_i;
        end else begin
            // Idle words flip so a stale sector never looks valid
            {key_action_o, key_function_o, key_word2_o} <= ~{key_action_o, key_function_o, key_word2_o};
            {key_word3_o, key_word4_o, key_rsvd_zero_o} <= ~{key_word3_o, key_word4_o, key_rsvd_zero_o};
        end
    end
endmodule

/* File: tb/tb_srf_cmd_ctrl.sv */
// Self-checking bench for the recovery and feature control decoder.
// Assumes the host model feeds key sectors; the bench drives media events.
module tb_srf_cmd_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

    // Short unit keeps timer runs brief
    localparam int UNIT = 10;
    // Longest wait covers the write limit set in the rows
    localparam int BOUND = 3000;

    typedef struct packed {
        logic [3:0]  act, fn, w2;
        logic [15:0] w3;
        logic [3:0]  w4, rz, abt;
        logic [15:0] ret;
    } srf_row_t;

    logic        clock_i    = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic        cold_rst_i = 1'b1;
    logic        s_go = 1'b0, s_w4 = 1'b0, s_rz = 1'b1;
    logic [15:0] s_act = 16'h0000, s_fn = 16'h0000, s_w2 = 16'h0000, s_w3 = 16'h0000;
    logic        mcmd_start_i = 1'b0, mcmd_write_i = 1'b0, mcmd_queued_i = 1'b0;
    logic        mcmd_in_order_i = 1'b0, mcmd_stream_i = 1'b0, mcmd_done_i = 1'b0;
    logic        key_valid_i, key_rsvd_zero_i, tf_done_o, nv_save_o, mcmd_timeout_o;
    logic [15:0] key_action_i, key_function_i, key_word2_i, key_word3_i, key_word4_i;
    logic [7:0]  tf_error_o, tf_sec_cnt_o, tf_sec_num_o, tf_status_o;
    logic [15:0] read_limit_o, write_limit_o, feat1_state_o, feat2_state_o, feat3_state_o;
    logic [15:0] nv_feature_o, nv_state_o;
    int          n_errors    = 0;
    int          check_count = 0;
    logic        got;
    // Action, function, selection, word 3, flag, reserved-zero, abort, answer
    srf_row_t    rows [16] = '{56'h321_0000_010_0000, 56'h311_0040_011_0000, 56'h311_0041_010_0000,
        56'h321_0000_010_0041, 56'h312_0123_010_0000, 56'h322_0000_010_0123, 56'h323_0000_011_0000,
        56'h421_0000_010_0001, 56'h412_0002_110_0000, 56'h422_0000_010_0002, 56'h432_0000_010_0001,
        56'h413_0005_010_0000, 56'h423_0000_010_0005, 56'h441_0000_011_0000, 56'h424_0000_011_0000,
        56'h421_0000_001_0000};

    srf_cmd_ctrl #(.UNIT_CYCLES(UNIT)) uut (.*);
    srf_host_model host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .send_i(s_go), .action_i(s_act),
        .function_i(s_fn), .word2_i(s_w2), .word3_i(s_w3), .persist_i(s_w4), .rsvd_zero_i(s_rz),
        .key_valid_o(key_valid_i), .key_action_o(key_action_i), .key_function_o(key_function_i),
        .key_word2_o(key_word2_i), .key_word3_o(key_word3_i), .key_word4_o(key_word4_i),
        .key_rsvd_zero_o(key_rsvd_zero_i));

    always #5 clock_i = ~clock_i;

    ////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One key sector; got tells whether done came within the bound
    task automatic send(input srf_row_t r);
        int n;
        @(posedge clock_i);
        s_go <= 1'b1;
        {s_act, s_fn, s_w2, s_w3} <= {12'h000, r.act, 12'h000, r.fn, 12'h000, r.w2, r.w3};
        {s_w4, s_rz} <= {r.w4[0], r.rz[0]};
        @(posedge clock_i);
        s_go <= 1'b0;
        n = 0;
        got = 1'b0;
        while (!got && n < 6) begin
            @(negedge clock_i);
            got = (tf_done_o === 1'b1);
            n++;
        end
    endtask

    // Free-running tick means the pulse lands anywhere in one unit
    task automatic run_timer(input logic [3:0] mode, input logic stop, timed, input int lim);
        int n;
        @(posedge clock_i);
        mcmd_start_i <= 1'b1;
        {mcmd_write_i, mcmd_queued_i, mcmd_in_order_i, mcmd_stream_i} <= mode;
        @(posedge clock_i);
        mcmd_start_i <= 1'b0;
        if (stop) begin
            repeat (100) @(posedge clock_i);
            mcmd_done_i <= 1'b1;
            @(posedge clock_i);
            mcmd_done_i <= 1'b0;
        end
        n = 0;
        while (mcmd_timeout_o !== 1'b1 && n < BOUND) begin
            @(negedge clock_i);
            n++;
        end
        `CHK(n >= (lim - 1) * UNIT && n <= lim * UNIT + 4, timed)
        if (timed && n >= BOUND) begin
            wrap_up();
        end
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock_i);
        sys_rst_i  <= 1'b0;
        cold_rst_i <= 1'b0;
        foreach (rows[i]) begin
            send(rows[i]);
            if (!got) begin
                n_errors++;
                wrap_up();
            end
            `CHK(tf_error_o, rows[i].abt[0] ? srf_pkg::SRF_ERR_ABORT : srf_pkg::SRF_ERR_NONE)
            `CHK(tf_status_o, rows[i].abt[0] ? srf_pkg::SRF_STAT_ERR : srf_pkg::SRF_STAT_OK)
            `CHK({tf_sec_num_o, tf_sec_cnt_o}, rows[i].ret)
        end
        `CHK(nv_feature_o, 16'h0002)
        `CHK(nv_state_o, 16'h0002)
        send(56'h511_0000_010_0000);
        `CHK(got, 1'b0)
        run_timer(4'h0, 1'h0, 1'h1, 'h41);
        run_timer(4'h8, 1'h0, 1'h1, 'h123);
        run_timer(4'h6, 1'h0, 1'h1, 'h41);
        run_timer(4'h4, 1'h0, 1'h0, 'h41);
        run_timer(4'h1, 1'h0, 1'h0, 'h41);
        run_timer(4'h0, 1'h1, 1'h0, 'h41);
        // Hard reset after the stopped run: limits clear, persistent state survives
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(negedge clock_i);
        `CHK(read_limit_o, 16'h0000)
        `CHK(write_limit_o, 16'h0000)
        `CHK(feat1_state_o, srf_pkg::SRF_FEAT_DEFAULT)
        `CHK(feat2_state_o, 16'h0002)
        `CHK(feat3_state_o, srf_pkg::SRF_FEAT_DEFAULT)
        run_timer(4'h0, 1'h0, 1'h0, 'h41);
        wrap_up();
    end
endmodule
